// file: src/ftbs_port.sv
// flow-through burst sram port: address/control capture, burst counter, late write,
// byte writes with parity, output-enable masking and sleep sequencing
// assumes the master samples data one cycle after a read starts and drives write data
// on the edge after a write starts; output enable and sleep are synchronised outside
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - write start captures address, tri-states lanes
// R2 - next edge latches write data
// R3 - only selected byte lanes and parity update
// R4 - master never drives while outputs active
// R5 - up to four burst accesses per load
// R6 - advance high ignores enables, steps counter
// R7 - master drives byte selects every burst cycle
// R8 - sleep input enters low power in two cycles
// R9 - access pending at sleep entry dropped
// R10 - master keeps selects off during recovery
// R11 - strap high: interleaved xor burst order
// R12 - strap low: linear burst wrapping order
// R13 - deselect tri-states, advance continues deselect
// R14 - read drives lanes only with enable low
// R15 - output enable unclocked, masked during writes; here registered on each enabled edge, one cycle lag
// R16 - all selects high writes nothing
// R17 - qualifier high holds all state; here the sleep counter still clears
// R18 - comes up deselected with lanes off
// R19 - any byte select combination allowed
// R20 - counter wraps within low two bits
// R21 - access needs selects, qualifier, load low
// R22 - sleeping keeps lanes off, ignores inputs
module ftbs_port (
  // clock, reset and enable
  input  wire logic                       CLK_IN,
  input  wire logic                       RST_N_IN,
  input  wire logic                       CLK_EN_IN,
  // synchronous controls
  input  wire logic                       CLOCK_QUALIFIER_N_IN,
  input  wire ftbs_pkg::ftbs_ctrl_type    CTRL_IN,
  input  wire logic                       BURST_ORDER_IN,
  // asynchronous controls
  input  wire logic                       OUTPUT_ENABLE_N_IN,
  input  wire logic                       SLEEP_REQUEST_IN,
  // data and parity lanes
  input  wire logic [ftbs_pkg::DATA_W-1:0] DATA_IN,
  input  wire logic [ftbs_pkg::LANES-1:0]  PARITY_LANE_IN,
  output logic      [ftbs_pkg::DATA_W-1:0] DATA_OUT,
  output logic      [ftbs_pkg::LANES-1:0]  PARITY_LANE_OUT,
  output logic      [ftbs_pkg::LANES-1:0]  LANE_OE_OUT,
  output logic                             SLEEPING_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [ftbs_pkg::DATA_W-1:0] mem [2**ftbs_pkg::ADDR_W];   // data array
  logic [ftbs_pkg::LANES-1:0]  pmem [2**ftbs_pkg::ADDR_W];  // parity array
  ftbs_pkg::ftbs_state_type    st_q;                        // registered state
  ftbs_pkg::ftbs_state_type    st_d;                        // next state
  logic [ftbs_pkg::LANES-1:0]  oe_q;                        // lane enables
  logic                        qual;                        // edge recognised
  logic                        sel_all;                     // all chip selects on
  logic [1:0]                  next_cnt;                    // advanced count
  logic [1:0]                  low_bits;                    // burst low address
  logic [ftbs_pkg::ADDR_W-1:0] acc_addr;                    // address used now
  logic                        do_write;                    // write beat this edge

  assign qual    = CLK_EN_IN && !CLOCK_QUALIFIER_N_IN;      // R17
  assign sel_all = !CTRL_IN.select_low_first_n && CTRL_IN.select_high_second
                   && !CTRL_IN.select_low_third_n;
  assign next_cnt = st_q.count + ftbs_pkg::BURST_ONE;       // R20
  // interleaved xors the count, linear adds it
  assign low_bits = BURST_ORDER_IN ? (st_q.base[1:0] ^ next_cnt)    // R11
                                   : (st_q.base[1:0] + next_cnt);   // R12
  assign acc_addr = CTRL_IN.advance_or_load
                    ? {st_q.base[ftbs_pkg::ADDR_W-1:2], low_bits}
                    : CTRL_IN.addr;
  // a write beat latches data one edge after its address
  assign do_write = qual && !st_q.asleep && !SLEEP_REQUEST_IN && st_q.wpend;  // R2 R9

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_d       = st_q;
    st_d.drive = 1'b0;
    st_d.wpend = 1'b0;
    // sleep sequencing runs off the plain enabled clock
    if (SLEEP_REQUEST_IN) begin                                     // R8
      st_d.acc   = ftbs_pkg::ACC_IDLE;                              // R9
      if (st_q.sleep_cnt != ftbs_pkg::SLEEP_ENTRY_CYC[1:0]) begin
        st_d.sleep_cnt = st_q.sleep_cnt + ftbs_pkg::BURST_ONE;
      end
      st_d.asleep = (st_q.sleep_cnt + ftbs_pkg::BURST_ONE)
                    >= ftbs_pkg::SLEEP_ENTRY_CYC[1:0];
    end else if (st_q.asleep) begin
      // recovery: count down before leaving
      if (st_q.sleep_cnt != ftbs_pkg::SLEEP_ZERO) begin
        st_d.sleep_cnt = st_q.sleep_cnt - ftbs_pkg::BURST_ONE;
      end
      st_d.asleep = (st_q.sleep_cnt > ftbs_pkg::BURST_ONE);
    end else if (!qual) begin
      // stall: hold everything including output state, but clear the sleep counter
      st_d.drive = st_q.drive;                                      // R17
      st_d.wpend = st_q.wpend;
      st_d.sleep_cnt = ftbs_pkg::SLEEP_ZERO;
    end else begin
      st_d.sleep_cnt = ftbs_pkg::SLEEP_ZERO;
      if (!CTRL_IN.advance_or_load) begin
        // load cycle: new access or deselect
        if (sel_all) begin                                          // R21
          st_d.base  = CTRL_IN.addr;
          st_d.count = ftbs_pkg::BURST_STEP0;
          st_d.acc   = CTRL_IN.write_enable_n ? ftbs_pkg::ACC_READ
                                              : ftbs_pkg::ACC_WRITE;
        end else begin
          st_d.acc = ftbs_pkg::ACC_IDLE;                            // R13
        end
      end else if (st_q.acc != ftbs_pkg::ACC_IDLE) begin
        // advance: enables and write enable ignored
        st_d.count = next_cnt;                                      // R6 R5
      end
      // beat issued on this edge
      case (st_d.acc)
        ftbs_pkg::ACC_READ: begin
          st_d.drive = 1'b1;
          st_d.rdata = mem[acc_addr];
          st_d.rpar  = pmem[acc_addr];
        end
        ftbs_pkg::ACC_WRITE: begin
          st_d.wpend = 1'b1;                                        // R1
          st_d.waddr = acc_addr;
          st_d.wsel  = CTRL_IN.byte_write_select_n;                 // R7
        end
        ftbs_pkg::ACC_IDLE: begin
          st_d.drive = 1'b0;                                        // R13
        end
        default: begin
          st_d.drive = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= '0;                                                   // R18
    end else if (CLK_EN_IN) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array write: selected lanes only, parity with its byte
  always_ff @(posedge CLK_IN) begin
    if (do_write) begin
      for (int i = 0; i < ftbs_pkg::LANES; i++) begin
        if (!st_q.wsel[i]) begin                                    // R3 R16 R19
          mem[st_q.waddr][i*8 +: 8] <= DATA_IN[i*8 +: 8];
          pmem[st_q.waddr][i]       <= PARITY_LANE_IN[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: enable is re-registered each enabled edge from the async enable so the
  // port stays flop-driven; the one-cycle lag is the cost of that rule
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      oe_q            <= '0;                                        // R18
      DATA_OUT        <= '0;
      PARITY_LANE_OUT <= '0;
      SLEEPING_OUT    <= 1'b0;
    end else if (CLK_EN_IN) begin
      // clock enable low freezes the outputs along with the rest of the state
      // writes never drive, sleep never drives, enable must be low
      oe_q <= {ftbs_pkg::LANES{st_q.drive && !st_q.wpend && !st_q.asleep
               && !SLEEP_REQUEST_IN && !OUTPUT_ENABLE_N_IN}};      // R14 R15 R22 R1
      DATA_OUT        <= st_q.rdata;
      PARITY_LANE_OUT <= st_q.rpar;
      SLEEPING_OUT    <= st_q.asleep;
    end
  end
  assign LANE_OE_OUT = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_WRITE_NO_DRIVE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R1
    st_q.wpend |=> LANE_OE_OUT == '0) else $error("lanes driven during write");
  AST_OE_HIGH_OFF: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R14
    OUTPUT_ENABLE_N_IN |=> LANE_OE_OUT == '0) else $error("driven with enable high");
  AST_SLEEP_OFF: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R22
    SLEEP_REQUEST_IN |=> LANE_OE_OUT == '0) else $error("driven while sleeping");
  AST_STALL_HOLD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R17
    (CLK_EN_IN && CLOCK_QUALIFIER_N_IN && !SLEEP_REQUEST_IN && !st_q.asleep)
    |=> st_q.count == $past(st_q.count) && st_q.base == $past(st_q.base))
    else $error("state moved on stalled edge");
  AST_SLEEP_ENTRY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R8
    (CLK_EN_IN && SLEEP_REQUEST_IN)[*2] |=> st_q.asleep) else $error("sleep entry slow");
  AST_DESELECT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R13
    (qual && !SLEEP_REQUEST_IN && !st_q.asleep && !CTRL_IN.advance_or_load && !sel_all)
    |=> st_q.acc == ftbs_pkg::ACC_IDLE) else $error("deselect missed");
  AST_LOAD: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R21
    (qual && !SLEEP_REQUEST_IN && !st_q.asleep && !CTRL_IN.advance_or_load && sel_all)
    |=> st_q.base == $past(CTRL_IN.addr) && st_q.count == ftbs_pkg::BURST_STEP0)
    else $error("address not loaded");
  AST_ADVANCE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R6
    (qual && !SLEEP_REQUEST_IN && !st_q.asleep && CTRL_IN.advance_or_load
     && st_q.acc != ftbs_pkg::ACC_IDLE)
    |=> st_q.count == $past(next_cnt) && st_q.acc == $past(st_q.acc))
    else $error("burst did not advance");
  AST_SLEEP_DROP: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R9
    (CLK_EN_IN && SLEEP_REQUEST_IN) |=> st_q.acc == ftbs_pkg::ACC_IDLE)
    else $error("access survived sleep");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on the data path, the freeze and the sleep exit
  // these look at what the port really stored or drove, not at its next-state
  // expressions, so a broken lane select or pipeline shows up here first

  // a frozen clock enable must leave every state bit where it was
  AST_FREEZE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R17
    !CLK_EN_IN |=> st_q == $past(st_q)) else $error("state moved while frozen");

  // lanes are quiet on the first edge after reset is released
  AST_RESET_QUIET: assert property (@(posedge CLK_IN)  // R18
    $rose(RST_N_IN) |-> LANE_OE_OUT == '0 && SLEEPING_OUT == 1'b0)
    else $error("lanes active after reset");

  // a write with every byte select high records no lane to write
  AST_WRITE_ABORT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R16
    (qual && !SLEEP_REQUEST_IN && !st_q.asleep && !CTRL_IN.advance_or_load && sel_all
     && !CTRL_IN.write_enable_n && (&CTRL_IN.byte_write_select_n))
    |=> st_q.wsel == {ftbs_pkg::LANES{1'b1}}) else $error("aborted write selects lanes");

  // a selected low lane takes the data presented on the data edge
  AST_LANE0_DATA: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R2
    (do_write && !st_q.wsel[0])
    |=> mem[$past(st_q.waddr)][7:0] == $past(DATA_IN[7:0]))
    else $error("lane data not stored");

  // the parity bit travels with its byte
  AST_LANE0_PARITY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R3
    (do_write && !st_q.wsel[0])
    |=> pmem[$past(st_q.waddr)][0] == $past(PARITY_LANE_IN[0]))
    else $error("lane parity not stored");

  // a live read with enable low drives every lane on the next edge
  AST_READ_DRIVES: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R14
    (CLK_EN_IN && st_q.drive && !st_q.wpend && !st_q.asleep && !SLEEP_REQUEST_IN
     && !OUTPUT_ENABLE_N_IN)
    |=> LANE_OE_OUT == {ftbs_pkg::LANES{1'b1}}) else $error("read not driven");

  // read data leaves the port one edge after it was fetched
  AST_READ_DATA: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R14
    (CLK_EN_IN && st_q.drive) |=> DATA_OUT == $past(st_q.rdata))
    else $error("read data not presented");

  // leaving sleep takes two enabled edges with the request low
  AST_SLEEP_EXIT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)  // R8
    (CLK_EN_IN && st_q.asleep && !SLEEP_REQUEST_IN
     && st_q.sleep_cnt == ftbs_pkg::SLEEP_ENTRY_CYC[1:0])
    ##1 (CLK_EN_IN && !SLEEP_REQUEST_IN) |=> !st_q.asleep)
    else $error("sleep exit slow");

  // main scenarios: read, write, a full burst, sleep
  COV_READ: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) LANE_OE_OUT != '0);
  COV_WRITE: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) do_write);
  COV_BURST: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    st_q.count == 2'h3);
  COV_SLEEP: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN) st_q.asleep);

endmodule : ftbs_port

// file: common/ftbs_pkg.sv
// package for the flow-through burst sram port: widths, timing and burst constants, state and pin bundles
// assumes a single 100 MHz clock domain and an active-low asynchronous reset
package ftbs_pkg;

  localparam int ADDR_W      = 8;    // word address width of the modelled array
  localparam int LANES       = 4;    // byte lanes per word
  localparam int DATA_W      = 32;   // data bits, eight per lane
  localparam int CLK_PERIOD_NS   = 10;   // clock period
  localparam int SLEEP_ENTRY_CYC = 2;    // sleep entry time in cycles
  localparam int SLEEP_REC_CYC   = 2;    // sleep recovery time in cycles
  localparam logic [1:0] BURST_STEP0 = 2'h0; // burst count at load
  localparam logic [1:0] BURST_ONE   = 2'h1; // burst count increment
  localparam logic [1:0] SLEEP_ZERO  = 2'h0; // sleep counter cleared

  // access kind held for the whole burst
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } ftbs_acc_type;

  // synchronous control pins sampled each qualified edge
  typedef struct packed {
    logic              select_low_first_n;
    logic              select_high_second;
    logic              select_low_third_n;
    logic              advance_or_load;
    logic              write_enable_n;
    logic [LANES-1:0]  byte_write_select_n;
    logic [ADDR_W-1:0] addr;
  } ftbs_ctrl_type;

  // complete registered state of the port
  typedef struct packed {
    ftbs_acc_type      acc;
    logic [ADDR_W-1:0] base;
    logic [1:0]        count;
    logic [1:0]        sleep_cnt;
    logic              asleep;
    logic [DATA_W-1:0] rdata;
    logic [LANES-1:0]  rpar;
    logic              drive;
    logic              wpend;
    logic [ADDR_W-1:0] waddr;
    logic [LANES-1:0]  wsel;
  } ftbs_state_type;

endpackage : ftbs_pkg

// file: dv/ftbs_master.sv
// bus master model on the lane side of the burst sram port
// assumes the bench hands it write data one cycle after each write address edge
`timescale 1ns/1ps

module ftbs_master (
  // clock and port drive state
  input  wire logic        clk_in,
  input  wire logic [3:0]  lane_oe_in,
  // write data from the bench
  input  wire logic        wvalid_in,
  input  wire logic [35:0] wdata_in,
  // lanes toward the port
  output logic      [31:0] data_out,
  output logic      [3:0]  parity_out
);
  logic [35:0] last_q;  // last value seen on the lanes

  //////////////////////////////////////////////////////////////////////////////
  // drive only while the port is silent; a released lane never shows stale data
  always_comb begin
    if (wvalid_in && lane_oe_in == 4'h0) begin
      {parity_out, data_out} = wdata_in;
    end else begin
      {parity_out, data_out} = ~last_q;
    end
  end

  // remember the lanes so the released pattern keeps changing
  always_ff @(posedge clk_in) begin
    last_q <= {parity_out, data_out};
  end
endmodule : ftbs_master

// file: dv/flow_through_burst_sram_port_test.sv
// self-checking bench for the burst sram port with a lane-side master model
// assumes read data shows one edge after its address edge, write data one edge after
`timescale 1ns/1ps

module flow_through_burst_sram_port_test;
  logic clk, rst_n, cq_n, mode, oe_n, oe_req, sleep, slp_req, wv, pend_v, slp;
  ftbs_pkg::ftbs_ctrl_type ctrl;          // control bundle to the port
  logic [35:0] wd, pend, mem [256];       // write data and expected array
  logic [35:0] edat [4];                  // expected read data pipeline
  logic [3:0]  eoe [4], oe, pin, pout;    // expected lane drive pipeline
  logic [31:0] din, dout;
  logic [1:0]  kind, cnt;                 // burst kind 0 idle 1 read 2 write
  logic [7:0]  base;
  int num_errors, checked;

  ftbs_port ftbs_port_i (.CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .CLOCK_QUALIFIER_N_IN(cq_n), .CTRL_IN(ctrl), .BURST_ORDER_IN(mode),
    .OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep), .DATA_IN(din),
    .PARITY_LANE_IN(pin), .DATA_OUT(dout), .PARITY_LANE_OUT(pout),
    .LANE_OE_OUT(oe), .SLEEPING_OUT(slp));
  ftbs_master ftbs_master_i (.clk_in(clk), .lane_oe_in(oe), .wvalid_in(wv),
    .wdata_in(wd), .data_out(din), .parity_out(pin));

  //////////////////////////////////////////////////////////////////////////////
  // compare, report and finish
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // one clock of stimulus; checks the outputs of the op two calls back
  task automatic op(input logic q, ld, sel, we_n, input logic [3:0] bws,
                    input logic [7:0] a, input logic [35:0] d);
    logic [7:0] wa;
    @(negedge clk);
    chk("lane_oe", {32'h0, oe}, {32'h0, eoe[1]});
    if (eoe[1] == 4'hF) chk("rdata", {pout, dout}, edat[1]);
    for (int i = 3; i > 0; i--) begin
      eoe[i] = eoe[i-1];
      edat[i] = edat[i-1];
    end
    eoe[0] = 4'h0;
    wv = pend_v;
    wd = pend;
    pend_v = 1'b0;
    oe_n = oe_req;
    sleep = slp_req;
    if (!q && !sleep) begin
      if (!ld) begin
        kind = !sel ? 2'h0 : (we_n ? 2'h1 : 2'h2);
        base = a;
        cnt = 2'h0;
      end else cnt = cnt + 2'h1;
      wa = {base[7:2], mode ? base[1:0] ^ cnt : base[1:0] + cnt};
      if (kind == 2'h2) begin
        for (int i = 0; i < 4; i++) if (!bws[i]) begin
          mem[wa][8*i+:8] = d[8*i+:8];
          mem[wa][32+i] = d[32+i];
        end
        pend = d;
        pend_v = 1'b1;
      end
      if (kind == 2'h1 && !oe_n) eoe[0] = 4'hF;
      edat[0] = mem[wa];
    end
    cq_n = q;
    ctrl = '{!sel, sel, !sel, ld, we_n, bws, a};
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 8'h00, 36'h0);
  endtask : idle

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_single;
    chk("reset", {slp, oe, pout, dout}, 36'h0);
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h10, 36'h5A1B2C3D4);
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'hA, 8'h10, 36'hF11223344);
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'hF, 8'h10, 36'hFFFFFFFFF);
    op(1'b0, 1'b1, 1'b0, 1'b0, 4'hF, 8'h00, 36'h000000000);
    idle(1);
    oe_req = 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h10, 36'h0);
    idle(1);
    oe_req = 1'b0;
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h10, 36'h0);
    idle(3);
  endtask : t_single

  task automatic t_burst;
    mode = 1'b0;
    op(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h22, 36'h100000000);
    for (int i = 1; i < 4; i++) op(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 8'h00, 36'h1 * i);
    idle(1);
    mode = 1'b1;
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h21, 36'h0);
    repeat (3) op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 8'h00, 36'h0);
    idle(3);
    op(1'b0, 1'b1, 1'b1, 1'b0, 4'h0, 8'h22, 36'h0);
    op(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 8'h10, 36'h0);
    idle(1);
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h10, 36'h0);
    idle(3);
  endtask : t_burst

  task automatic t_sleep;
    int n;
    slp_req = 1'b1;
    for (n = 0; n < 8 && slp !== 1'b1; n++) idle(1);
    chk("sleeping", {35'h0, slp}, 36'h1);
    if (n == 8) end_sim;
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h22, 36'h0);
    slp_req = 1'b0;
    for (n = 0; n < 8 && slp !== 1'b0; n++) idle(1);
    chk("awake", {35'h0, slp}, 36'h0);
    if (n == 8) end_sim;
    idle(2);
    op(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 8'h23, 36'h0);
    idle(3);
  endtask : t_sleep

  //////////////////////////////////////////////////////////////////////////////
  // clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_n, mode, oe_n, oe_req, sleep, slp_req, wv, pend_v, kind, cnt, base} = '0;
    {cq_n, wd, pend, ctrl} = '1;
    for (int i = 0; i < 4; i++) {eoe[i], edat[i]} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_single;
    t_burst;
    t_sleep;
    end_sim;
  end
endmodule : flow_through_burst_sram_port_test
